/* logic/ssc_top.sv */
// Purpose: four priority sample sequencers steering one converter
// Assumes: trigger events and fifo pops are one-cycle pulses
// Notes:   result fifos sit outside; this block tracks their fill
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"
module ssc_top
  import ssc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             seq_enable,
  input  wire logic [15:0]            trig_src,
  input  wire logic [7:0]             seq_prio,
  input  wire logic [3:0]             trig_evt,
  input  wire logic                   proc_trig,
  input  wire ssc_pkg::ssc_seq_t      sequence_index,
  input  wire ssc_pkg::ssc_step_s [`SSC_NUM_STEPS-1:0] step_cfg,
  input  wire logic [6:0]             average_factor,
  input  wire logic                   conv_done,
  input  wire ssc_pkg::ssc_sample_t   conv_data,
  input  wire logic [3:0]             fifo_pop,
  input  wire logic                   int_clear,
  input  wire logic                   int_enable,
  input  wire logic                   int_disable,
  input  wire logic                   ovf_clear,
  input  wire logic                   masked_status_select,
  output logic                        conv_start,
  output logic [3:0]                  conv_chan,
  output logic                        fifo_push,
  output ssc_pkg::ssc_result_s        fifo_result,
  output logic [3:0]                  int_raw,
  output logic [3:0]                  int_masked,
  output logic                        int_status,
  output logic [3:0]                  ovf_flag,
  output logic                        busy
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ssc_state_e  st_q, st_d;
  ssc_seq_t    seq_q, seq_d;
  logic [2:0]  step_q, step_d;
  logic [2:0]  logf_q, logf_d;
  logic [3:0]  pend_q, pend_d;
  logic [3:0]  cnt_q [4];
  logic [3:0]  cnt_d [4];
  logic [3:0]  raw_q, raw_d;
  logic [3:0]  mask_q, mask_d;
  logic [3:0]  ovf_q, ovf_d;
  logic        start_q, start_d;
  logic [3:0]  chan_q, chan_d;
  logic        push_q, push_d;
  ssc_result_s res_q, res_d;
  logic        stat_q, stat_d;
  logic        busy_q, busy_d;
  logic [3:0]  mskd_q, mskd_d;
  logic [3:0]  trig_hit;
  logic [3:0]  done_seq;
  logic [3:0]  ie_hit;
  logic        grant_vld;
  logic [1:0]  grant_idx;
  logic        avg_vld;
  ssc_sample_t avg_data;
  logic [4:0]  cur_idx;
  ssc_step_s   cur_step;
  logic        step_end;
  logic [3:0]  sel;

  // step table base and depth of each sequencer
  function automatic logic [4:0] seq_base(input logic [1:0] s);
    case (s)
      2'h0:    seq_base = `SSC_BASE0;
      2'h1:    seq_base = `SSC_BASE1;
      2'h2:    seq_base = `SSC_BASE2;
      default: seq_base = `SSC_BASE3;
    endcase
  endfunction

  function automatic logic [3:0] seq_depth(input logic [1:0] s);
    case (s)
      2'h0:    seq_depth = 4'(`SSC_DEPTH0); // RULE1
      2'h1:    seq_depth = 4'(`SSC_DEPTH1);
      2'h2:    seq_depth = 4'(`SSC_DEPTH2);
      default: seq_depth = 4'(`SSC_DEPTH3);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // trigger qualification
  // ----------------------------------------------------------------
  // a disabled sequencer ignores its trigger altogether
  always_comb begin
    sel = 4'h0;
    sel[sequence_index] = 1'b1;
    for (int s = 0; s < 4; s++) begin
      if (trig_src[4*s +: 4] == `SSC_TRIG_PROC) begin
        trig_hit[s] = seq_enable[s] && proc_trig && sel[s]; // RULE17
      end else if (trig_src[4*s +: 4] == `SSC_TRIG_ALWAYS) begin
        trig_hit[s] = seq_enable[s];                        // RULE4
      end else begin
        trig_hit[s] = seq_enable[s] && trig_evt[s];         // RULE4
      end
    end
  end

  ssc_arb u_arb (
    .pend      (pend_q & seq_enable),
    .prio      (seq_prio),
    .grant_vld (grant_vld),
    .grant_idx (grant_idx)
  );

  // factor is latched at sequence start so a run never mixes factors
  ssc_avg u_avg (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (st_q == SSC_IDLE),
    .log_f    (logf_q),
    .in_vld   (st_q == SSC_WAIT && conv_done),
    .in_data  (conv_data),
    .out_vld  (avg_vld),
    .out_data (avg_data)
  );

  // ----------------------------------------------------------------
  // sequencer state machine
  // ----------------------------------------------------------------
  always_comb begin
    cur_idx  = seq_base(seq_q) + {2'h0, step_q};
    cur_step = step_cfg[cur_idx];
    step_end = cur_step.last || ({1'b0, step_q} == seq_depth(seq_q) - 4'h1);
    st_d     = st_q;
    seq_d    = seq_q;
    step_d   = step_q;
    logf_d   = logf_q;
    start_d  = 1'b0;
    chan_d   = chan_q;
    push_d   = 1'b0;
    res_d    = res_q;
    done_seq = 4'h0;
    ie_hit   = 4'h0;
    case (st_q)
      SSC_IDLE: begin
        if (grant_vld) begin // RULE5
          seq_d  = grant_idx;
          step_d = 3'h0;
          logf_d = 3'h0;     // RULE8
          for (int k = 1; k <= 6; k++) begin
            if (average_factor == 7'(1 << k)) begin
              logf_d = 3'(k); // RULE7 RULE10
            end
          end
          st_d = SSC_START;
        end
      end
      SSC_START: begin
        start_d = 1'b1;
        chan_d  = cur_step.chan; // RULE2 RULE3
        st_d    = SSC_WAIT;
      end
      SSC_WAIT: begin
        // further conversions of the same input until the group is full
        if (conv_done) begin
          st_d = SSC_DONE;
        end
      end
      default: begin
        if (avg_vld) begin
          push_d   = 1'b1;                   // RULE11
          res_d    = '{seq: seq_q, data: avg_data};
          ie_hit[seq_q] = cur_step.ie;       // RULE20
          if (step_end) begin
            done_seq[seq_q] = 1'b1;
            st_d = SSC_IDLE;
          end else begin
            step_d = step_q + 3'h1;
            st_d   = SSC_START;
          end
        end else begin
          st_d = SSC_START;                  // RULE9 RULE12
        end
      end
    endcase
    busy_d = (st_d != SSC_IDLE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= SSC_IDLE;
      seq_q   <= 2'h0;
      step_q  <= 3'h0;
      logf_q  <= 3'h0;
      start_q <= 1'b0;
      chan_q  <= 4'h0;
      push_q  <= 1'b0;
      res_q   <= '0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      seq_q   <= seq_d;
      step_q  <= step_d;
      logf_q  <= logf_d;
      start_q <= start_d;
      chan_q  <= chan_d;
      push_q  <= push_d;
      res_q   <= res_d;
      busy_q  <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // pending, fill count, overflow and interrupt flags
  // ----------------------------------------------------------------
  // a new trigger beats the completion clearing the pending bit
  always_comb begin
    pend_d = pend_q;
    raw_d  = raw_q;
    mask_d = mask_q;
    ovf_d  = ovf_q;
    for (int s = 0; s < 4; s++) begin
      cnt_d[s] = cnt_q[s];
      if (push_d && res_d.seq == s[1:0] && cnt_q[s] != seq_depth(s[1:0])) begin
        cnt_d[s] = cnt_d[s] + 4'h1;
      end
      if (fifo_pop[s] && cnt_q[s] != 4'h0) begin
        cnt_d[s] = cnt_d[s] - 4'h1;
      end
      if (done_seq[s]) begin
        pend_d[s] = 1'b0;
      end
      if (trig_hit[s]) begin
        pend_d[s] = 1'b1;
      end
      if (ovf_clear && sel[s]) begin
        ovf_d[s] = 1'b0;
      end
      if (trig_hit[s] && cnt_q[s] != 4'h0) begin
        ovf_d[s] = 1'b1;                 // RULE19
      end
      if (int_disable && sel[s]) begin
        mask_d[s] = 1'b0;                // RULE15
      end
      if ((int_clear || int_enable) && sel[s]) begin
        raw_d[s] = 1'b0;                 // RULE13 RULE15
      end
      if (int_enable && sel[s]) begin
        mask_d[s] = 1'b1;                // RULE15
      end
      if (ie_hit[s]) begin
        raw_d[s] = 1'b1;                 // RULE20
      end
    end
    // status read for the addressed sequence
    stat_d = masked_status_select ? (raw_d[sequence_index] & mask_d[sequence_index])
                                  : raw_d[sequence_index]; // RULE16
    mskd_d = raw_d & mask_d;                                 // RULE16
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 4'h0;
      raw_q  <= 4'h0;
      mask_q <= 4'h0;
      ovf_q  <= 4'h0;
      stat_q <= 1'b0;
      mskd_q <= 4'h0;
      for (int s = 0; s < 4; s++) begin
        cnt_q[s] <= `SSC_RST_CNT;
      end
    end else begin
      pend_q <= pend_d;
      raw_q  <= raw_d;
      mask_q <= mask_d;
      ovf_q  <= ovf_d;
      stat_q <= stat_d;
      mskd_q <= mskd_d;
      for (int s = 0; s < 4; s++) begin
        cnt_q[s] <= cnt_d[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign conv_start  = start_q;
  assign conv_chan   = chan_q;
  assign fifo_push   = push_q;
  assign fifo_result = res_q;
  assign int_raw     = raw_q;
  assign int_masked  = mskd_q; // RULE16
  assign int_status  = stat_q;
  assign ovf_flag    = ovf_q;
  assign busy        = busy_q;
endmodule
`default_nettype wire

/* logic/ssc_map.svh */
// Purpose: constants of the converter sample sequencer control
// Assumes: included by its bare name from package and modules
// Notes:   Contract list below; offsets are step table positions
// Contract
// [RULE1] four sequencers holding eight, four, four, one
// [RULE2] eight external channels plus temperature sensor
// [RULE3] each step picks any input independently
// [RULE4] each sequencer has its own trigger source
// [RULE5] highest priority pending sequence sampled first
// [RULE6] software keeps frequent triggers at low priority
// [RULE7] averaging by 2, 4, 8, 16, 32, 64
// [RULE8] factor zero stores every conversion unaveraged
// [RULE9] average taken from same input, consecutive conversions
// [RULE10] one factor for all sequencers, full depth kept
// [RULE11] fifo only receives complete averaged readings
// [RULE12] result rate drops by the averaging factor
// [RULE13] clear request drops that sequence interrupt source
// [RULE14] software clears interrupt early in its handler
// [RULE15] per sequence enable; enabling discards pending interrupt
// [RULE16] raw and masked status reported per sequence
// [RULE17] processor trigger acts only with processor source
// [RULE18] priority 0 highest through 3 lowest
// [RULE19] trigger with unread samples sets sticky overflow
// [RULE20] interrupt step completion sets sticky raw status
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// ----------------------------------------------------------------
// step table layout
// ----------------------------------------------------------------
`define SSC_NUM_SEQ     4
`define SSC_NUM_STEPS   17
`define SSC_DEPTH0      8
`define SSC_DEPTH1      4
`define SSC_DEPTH2      4
`define SSC_DEPTH3      1
`define SSC_BASE0       5'h00
`define SSC_BASE1       5'h08
`define SSC_BASE2       5'h0C
`define SSC_BASE3       5'h10
// ----------------------------------------------------------------
// input and trigger codes
// ----------------------------------------------------------------
`define SSC_CHAN_TEMP   4'h8
`define SSC_TRIG_PROC   4'h0
`define SSC_TRIG_ALWAYS 4'hF
`define SSC_SAMPLE_W    12
`define SSC_LOG_MAX     3'h6
`define SSC_RST_CNT     4'h0
`endif

/* logic/ssc_pkg.sv */
// Purpose: shared types of the sample sequencer control
// Assumes: ssc_map.svh supplies the widths
// Notes:   types only, constants live in the header
`include "ssc_map.svh"
package ssc_pkg;
  typedef logic [1:0]               ssc_seq_t;
  typedef logic [`SSC_SAMPLE_W-1:0] ssc_sample_t;
  // one sequence step: input select, interrupt request, last step
  typedef struct packed {
    logic [3:0] chan;
    logic       ie;
    logic       last;
  } ssc_step_s;
  // one result headed for a sequence fifo
  typedef struct packed {
    ssc_seq_t    seq;
    ssc_sample_t data;
  } ssc_result_s;
  typedef enum logic [1:0] {
    SSC_IDLE  = 2'b00,
    SSC_START = 2'b01,
    SSC_WAIT  = 2'b10,
    SSC_DONE  = 2'b11
  } ssc_state_e;
endpackage

/* logic/ssc_arb.sv */
// Purpose: pick the pending sequence of best priority
// Assumes: priorities unique; ties fall to the lower index
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module ssc_arb (
  input  wire logic [3:0] pend,
  input  wire logic [7:0] prio,
  output logic            grant_vld,
  output logic [1:0]      grant_idx
);
  // ----------------------------------------------------------------
  // scan levels 3 to 0 (best), last hit wins
  // ----------------------------------------------------------------
  always_comb begin
    grant_vld = 1'b0;
    grant_idx = 2'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 3; s >= 0; s--) begin
        if (pend[s] && prio[2*s +: 2] == l[1:0]) begin // RULE5 RULE18
          grant_vld = 1'b1;
          grant_idx = s[1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* logic/ssc_avg.sv */
// Purpose: hardware averager between converter and result fifo
// Assumes: log2 factor stable while a step converts
// Notes:   result is the truncated mean of 2^log_f samples
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"
module ssc_avg
  import ssc_pkg::*;
#(
  parameter int W = `SSC_SAMPLE_W
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic [2:0]   log_f,
  input  wire logic         in_vld,
  input  wire logic [W-1:0] in_data,
  output logic              out_vld,
  output logic [W-1:0]      out_data
);
  logic [W+5:0] acc_q, acc_d, sum;
  logic [5:0]   cnt_q, cnt_d;
  logic [5:0]   last_cnt;
  logic         vld_q, vld_d;
  logic [W-1:0] dat_q, dat_d;

  // ----------------------------------------------------------------
  // accumulate, emit only when the whole group is in
  // ----------------------------------------------------------------
  always_comb begin
    last_cnt = 6'((7'h01 << log_f) - 7'h01);
    sum      = acc_q + {6'h00, in_data};
    acc_d    = acc_q;
    cnt_d    = cnt_q;
    vld_d    = 1'b0;
    dat_d    = dat_q;
    if (flush) begin
      acc_d = '0;
      cnt_d = 6'h00;
    end else if (in_vld) begin
      if (cnt_q == last_cnt) begin // RULE11 RULE12
        vld_d = 1'b1;
        dat_d = W'(sum >> log_f);  // RULE7 RULE8
        acc_d = '0;
        cnt_d = 6'h00;
      end else begin
        acc_d = sum;               // RULE9
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      cnt_q <= 6'h00;
      vld_q <= 1'b0;
      dat_q <= '0;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      dat_q <= dat_d;
    end
  end

  assign out_vld  = vld_q;
  assign out_data = dat_q;
endmodule
`default_nettype wire

/* dv/ssc_conv_model.sv */
// Purpose: converter stand-in, one result per conversion start
// Assumes: conv_start is a one-cycle pulse
// Notes:   latency varies per start; data line scrambles between results
`timescale 1ns/100ps
`default_nettype none
module ssc_conv_model (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            conv_start,
  output logic                 conv_done,
  output ssc_pkg::ssc_sample_t conv_data
);
  import ssc_pkg::*;
  int         seed = 32'h3C5A0F17;
  logic [3:0] wait_q;
  // count down a random latency, then pulse done with fresh data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q    <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data; // a stale value must never look valid
      if (conv_start) begin
        wait_q <= 4'(1 + ($unsigned($random(seed)) % 8));
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          conv_done <= 1'b1;
          conv_data <= ssc_sample_t'($random(seed));
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ssc_top_checker.sv */
// Purpose: port assertions of the sample sequencer control
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to ssc_top after the module
`timescale 1ns/100ps
`default_nettype none
module ssc_top_checker (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire ssc_pkg::ssc_seq_t    sequence_index,
  input wire logic                 int_clear,
  input wire logic                 int_enable,
  input wire logic                 int_disable,
  input wire logic                 ovf_clear,
  input wire logic                 masked_status_select,
  input wire logic                 conv_start,
  input wire logic [3:0]           conv_chan,
  input wire logic                 fifo_push,
  input wire ssc_pkg::ssc_result_s fifo_result,
  input wire logic [3:0]           int_raw,
  input wire logic [3:0]           int_masked,
  input wire logic                 int_status,
  input wire logic [3:0]           ovf_flag,
  input wire logic                 busy
);
  import ssc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a start is a lone pulse while busy, channel held behind it
  sequence s_start; conv_start && busy; endsequence
  sequence s_held; !conv_start && $stable(conv_chan); endsequence
  property p_conv_pulse; conv_start |-> s_start ##1 s_held; endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse bad");
  property p_push_pulse; fifo_push |=> !fifo_push; endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push pulse bad");
  property p_mask; (int_masked & ~int_raw) == 4'h0; endproperty
  a_mask: assert property (p_mask) else $error("masked beyond raw");
  property p_mask_keep;
    |($past(int_masked) & ~int_masked & int_raw) |-> $past(int_disable);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask lost");
  property p_status;
    1'b1 |=> int_status == ($past(masked_status_select) ?
      int_masked[$past(sequence_index)] : int_raw[$past(sequence_index)]);
  endproperty
  a_status: assert property (p_status) else $error("status select wrong");
  property p_clear;
    int_clear || int_enable |=> !int_raw[$past(sequence_index)] ||
      (fifo_push && fifo_result.seq == $past(sequence_index));
  endproperty
  a_clear: assert property (p_clear) else $error("raw not cleared");
  property p_disable; int_disable |=> !int_masked[$past(sequence_index)]; endproperty
  a_disable: assert property (p_disable) else $error("mask not dropped");
  // a raw bit rises only with the push of its own sequence
  property p_raw_rise;
    |(int_raw & ~$past(int_raw)) |->
      fifo_push && (int_raw & ~$past(int_raw)) == (4'h1 << fifo_result.seq);
  endproperty
  a_raw_rise: assert property (p_raw_rise) else $error("raw rose alone");
  property p_raw_fall; |($past(int_raw) & ~int_raw) |-> $past(int_clear || int_enable); endproperty
  a_raw_fall: assert property (p_raw_fall) else $error("raw fell alone");
  property p_ovf_fall; |($past(ovf_flag) & ~ovf_flag) |-> $past(ovf_clear); endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow fell alone");
endmodule
bind ssc_top ssc_top_checker ssc_top_checker_i (.clock(clock), .rst_n(rst_n),
  .sequence_index(sequence_index), .int_clear(int_clear), .int_enable(int_enable),
  .int_disable(int_disable), .ovf_clear(ovf_clear), .masked_status_select(masked_status_select),
  .conv_start(conv_start), .conv_chan(conv_chan), .fifo_push(fifo_push),
  .fifo_result(fifo_result), .int_raw(int_raw), .int_masked(int_masked),
  .int_status(int_status), .ovf_flag(ovf_flag), .busy(busy));
`default_nettype wire

/* dv/ssc_top_test.sv */
// Purpose: self-checking bench of the sample sequencer control
// Assumes: converter model answers every start once
// Notes:   expectations follow the step table and the factor
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"
module ssc_top_test;
  import ssc_pkg::*;
  logic        clock, rst_n, proc_trig, conv_start, conv_done, fifo_push, busy;
  logic        int_clear, int_enable, int_disable, ovf_clear, masked_status_select, int_status;
  logic [3:0]  seq_enable, trig_evt, fifo_pop, conv_chan, int_raw, int_masked, ovf_flag;
  logic [3:0]  exp_raw, exp_mask, exp_ovf;
  logic [15:0] trig_src;
  logic [7:0]  seq_prio;
  logic [6:0]  average_factor;
  logic [31:0] acc;
  ssc_seq_t    sequence_index;
  ssc_sample_t conv_data;
  ssc_result_s fifo_result;
  ssc_step_s   [`SSC_NUM_STEPS-1:0] step_cfg;
  int          seed = int'(32'h9AD6A1D3);
  int          fails = 0, total_checks = 0, cyc = 0, n = 0, k;
  int          exp_q[$];
  int          fill[4] = '{0, 0, 0, 0};
  int          base[4] = '{0, 8, 12, 16};
  int          depth[4] = '{8, 4, 4, 1};
  int          ft[8] = '{0, 2, 4, 8, 16, 32, 64, 3};
  ssc_top ssc_top_i (.clock(clock), .rst_n(rst_n), .seq_enable(seq_enable),
    .trig_src(trig_src), .seq_prio(seq_prio), .trig_evt(trig_evt), .proc_trig(proc_trig),
    .sequence_index(sequence_index), .step_cfg(step_cfg), .average_factor(average_factor),
    .conv_done(conv_done), .conv_data(conv_data), .fifo_pop(fifo_pop), .int_clear(int_clear),
    .int_enable(int_enable), .int_disable(int_disable), .ovf_clear(ovf_clear),
    .masked_status_select(masked_status_select), .conv_start(conv_start),
    .conv_chan(conv_chan), .fifo_push(fifo_push), .fifo_result(fifo_result),
    .int_raw(int_raw), .int_masked(int_masked), .int_status(int_status),
    .ovf_flag(ovf_flag), .busy(busy));
  ssc_conv_model ssc_conv_model_i (.clock(clock), .rst_n(rst_n), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [1:0] seq_of(input int s);
    return (s < 8) ? 2'h0 : (s < 12) ? 2'h1 : (s < 16) ? 2'h2 : 2'h3;
  endfunction
  // invalid factors fall back to one conversion per result
  function automatic logic [6:0] f_eff();
    return (average_factor inside {7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40}) ?
      average_factor : 7'h01;
  endfunction
  // scoreboard: averages conversions per step and checks each push
  always @(posedge clock) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      test_done();
    end
    if (rst_n && conv_done) begin
      acc += conv_data;
      n++;
      if (exp_q.size() != 0) chk("conv_chan", 16'(conv_chan), 16'(step_cfg[exp_q[0]].chan));
    end
    if (rst_n && fifo_push) begin
      if (exp_q.size() == 0) chk("stray_push", 16'h0001, 16'h0000);
      else begin
        k = exp_q.pop_front();
        chk("push_seq", 16'(fifo_result.seq), 16'(seq_of(k)));
        chk("push_data", 16'(fifo_result.data), 16'(acc / f_eff()));
        chk("conv_count", 16'(n), 16'(f_eff()));
        if (step_cfg[k].ie) exp_raw[seq_of(k)] = 1'b1;
        if (fill[seq_of(k)] < depth[seq_of(k)]) fill[seq_of(k)]++;
      end
      acc = 0;
      n = 0;
    end
  end
  task automatic exp_add(input int s);
    if (fill[s] != 0) exp_ovf[s] = 1'b1;
    for (int j = base[s]; j < base[s] + depth[s]; j++) begin
      exp_q.push_back(j);
      if (step_cfg[j].last) break;
    end
  endtask
  task automatic fire(input int s);
    exp_add(s);
    if (trig_src[4*s+:4] == `SSC_TRIG_PROC) begin
      sequence_index = 2'(s);
      proc_trig = 1'b1;
    end else trig_evt[s] = 1'b1;
    @(posedge clock); #1;
    proc_trig = 1'b0;
    trig_evt = 4'h0;
  endtask
  task automatic settle();
    for (int i = 0; i < 30000 && (exp_q.size() != 0 || busy !== 1'b0); i++) @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    chk("busy", 16'(busy), 16'h0000);
    chk("missing_push", 16'(exp_q.size()), 16'h0000);
    chk("int_raw", 16'(int_raw), 16'(exp_raw));
    chk("int_masked", 16'(int_masked), 16'(exp_raw & exp_mask));
    chk("ovf_flag", 16'(ovf_flag), 16'(exp_ovf));
  endtask
  task automatic pop_some();
    repeat ($unsigned($random(seed)) % 8) begin
      fifo_pop = 4'($random(seed));
      for (int s = 0; s < 4; s++) if (fifo_pop[s] && fill[s] > 0) fill[s]--;
      @(posedge clock); #1;
    end
    fifo_pop = 4'h0;
  endtask
  task automatic int_op(input int s, input int op);
    sequence_index = 2'(s);
    masked_status_select = 1'($random(seed));
    case (op)
      0: begin int_clear = 1'b1; exp_raw[s] = 1'b0; end
      1: begin int_enable = 1'b1; exp_raw[s] = 1'b0; exp_mask[s] = 1'b1; end
      2: begin int_disable = 1'b1; exp_mask[s] = 1'b0; end
      default: begin ovf_clear = 1'b1; exp_ovf[s] = 1'b0; end
    endcase
    @(posedge clock); #1;
    {int_clear, int_enable, int_disable, ovf_clear} = 4'h0;
    @(posedge clock); #1;
    chk("int_status", 16'(int_status), 16'(masked_status_select ? exp_raw[s] & exp_mask[s] : exp_raw[s]));
  endtask
  // unique random priorities, random steps, sources and factor
  task automatic randomize_cfg();
    logic [1:0] p[4];
    logic [1:0] t;
    int         j;
    for (int i = 0; i < 4; i++) p[i] = 2'(i);
    for (int i = 0; i < 4; i++) begin
      j = $unsigned($random(seed)) % 4;
      t = p[i];
      p[i] = p[j];
      p[j] = t;
    end
    seq_prio = {p[3], p[2], p[1], p[0]};
    for (int i = 0; i < `SSC_NUM_STEPS; i++)
      step_cfg[i] = '{chan: 4'($unsigned($random(seed)) % 9), ie: 1'($random(seed)),
                      last: ($unsigned($random(seed)) % 4 == 0)};
    // processor or event codes only: a free-running source would starve the others
    for (int i = 0; i < 4; i++)
      trig_src[4*i+:4] = $random(seed) & 1 ? 4'h0 : 4'(1 + $unsigned($random(seed)) % 14);
    average_factor = 7'(ft[$unsigned($random(seed)) % 8]);
  endtask
  initial begin
    {rst_n, proc_trig, int_clear, int_enable, int_disable, ovf_clear} = 6'h00;
    {trig_evt, fifo_pop, exp_raw, exp_mask, exp_ovf} = 20'h00000;
    {masked_status_select, sequence_index, average_factor, acc} = '0;
    {seq_enable, trig_src, seq_prio, step_cfg} = {4'hF, 16'h0000, 8'hE4, 102'h0};
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("reset", {int_raw, ovf_flag, int_masked, busy, fifo_push, conv_start, int_status}, 16'h0000);
    // every factor, full-depth chains over all inputs and sequences
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < `SSC_NUM_STEPS; j++)
        step_cfg[j] = '{chan: 4'((i + j) % 9), ie: 1'b1, last: 1'b0};
      average_factor = 7'(ft[i]);
      fire(i % 4);
      settle();
      pop_some();
    end
    for (int op = 1; op < 5; op++)
      for (int s = 0; s < 4; s++) int_op(s, op % 4);
    // processor start on an event-fed sequence, then a disabled sequence
    trig_src = 16'h1111;
    sequence_index = 2'h2;
    proc_trig = 1'b1;
    @(posedge clock); #1;
    proc_trig = 1'b0;
    seq_enable = 4'hB;
    trig_evt = 4'h4;
    @(posedge clock); #1;
    trig_evt = 4'h0;
    settle();
    seq_enable = 4'hF;
    // one cycle of the free-running code gives exactly one capture
    trig_src = 16'hF111;
    exp_add(3);
    @(posedge clock); #1;
    trig_src = 16'h1111;
    settle();
    // all four at once: captured in priority order
    for (int r = 0; r < 5; r++) begin
      randomize_cfg();
      trig_src = 16'h2345;
      for (int p = 0; p < 4; p++)
        for (int s = 0; s < 4; s++) if (seq_prio[2*s+:2] == p) exp_add(s);
      trig_evt = 4'hF;
      @(posedge clock); #1;
      trig_evt = 4'h0;
      settle();
      pop_some();
    end
    for (int r = 0; r < 30; r++) begin
      randomize_cfg();
      fire($unsigned($random(seed)) % 4);
      settle();
      pop_some();
      int_op($unsigned($random(seed)) % 4, $unsigned($random(seed)) % 4);
    end
    settle();
    test_done();
  end
endmodule
`default_nettype wire
